// >>> hw/flash_security_command_gate.sv
// Flash security command gate: APB registers, command sequencer, flag store.
// Assumes a flash engine on the same clock that pulses flash_done per command.
`timescale 1ns/10ps
module flash_security_command_gate
    import fsg_pkg::*;
#(
    parameter bit SINGLE_SUPPLY = 1'b1 // Zero builds the two-supply variant
)(
    input  wire logic        clk,         // 10 MHz system clock
    input  wire logic        rst_n,       // Asynchronous reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB write
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic             pready,      // APB ready
    output logic [31:0]      prdata,      // APB read data
    output logic             pslverr,     // APB error on unmapped address
    input  wire logic        flash_done,  // Flash engine finished the operation
    output logic             flash_start, // One-cycle start to the flash engine
    output logic [2:0]       flash_op,    // Operation for the flash engine
    output logic [7:0]       flash_first, // First block for the flash engine
    output logic [7:0]       flash_last,  // Last block for the flash engine
    output logic             irq          // Level interrupt
);
    // Idle waits for a command, check forms the verdict in one cycle,
    // run waits on the flash engine; a security command never enters run
    // because it only touches the flag store
    typedef enum logic [1:0] {S_IDLE, S_CHECK, S_RUN} state_e;

    state_e              state_r;      // Sequencer state
    logic                pready_r;     // Registered ready
    logic [31:0]         prdata_r;     // Registered read data
    logic                pslverr_r;    // Registered error
    logic [2:0]          op_r;         // Command held for checking
    logic [7:0]          first_r;      // Held first block
    logic [7:0]          last_r;       // Held last block
    logic [NFLAGS-1:0]   req_flags_r;  // Flags staged for the next security command
    logic [7:0]          req_end_r;    // End boot block staged
    logic [NFLAGS-1:0]   flags_r;      // Enforced flags
    logic [7:0]          boot_end_r;   // Enforced end boot block
    logic                acc_r;        // Last command accepted
    logic                rej_r;        // Last command rejected
    logic [NIRQ-1:0]     int_stat_r;   // Sticky interrupt status
    logic [NIRQ-1:0]     int_mask_r;   // Interrupt enables
    logic                start_r;      // Flash start pulse
    logic [2:0]          fop_r;        // Flash operation
    logic [7:0]          ffirst_r;     // Flash first block
    logic [7:0]          flast_r;      // Flash last block
    logic                irq_r;        // Interrupt output

    // Decode and event strobes, all combinational on the same clock
    logic                acc_en;       // Access completes this edge
    logic                wr_en;        // Write completes this edge
    logic                mapped;       // Address decodes to a register
    logic                cmd_wr;       // Command register written
    logic                allow;        // Checker verdict
    logic                ev_done;      // Command finished event
    logic                ev_rej;       // Command rejected event
    logic [31:0]         rd_mux;       // Read data before the register
    logic [NFLAGS-1:0]   flag_mask;    // Flags that exist in this variant

    // Boot protect bit is absent in the two-supply build
    assign flag_mask = SINGLE_SUPPLY ? 5'h1F : 5'h0F;

    // An access completes on the edge where ready is already high, so a write
    // lands exactly once even if select stays up for a following setup
    assign acc_en = psel && penable && pready_r;
    assign wr_en  = acc_en && pwrite;
    assign mapped = (paddr == CMD_OFS) || (paddr == SEC_REQ_OFS) || (paddr == FLAGS_OFS)
                 || (paddr == STATUS_OFS) || (paddr == INT_STAT_OFS)
                 || (paddr == INT_MASK_OFS);
    // Commands written while busy are dropped; software polls busy first
    // A dropped write raises no error, so the host must read the result bits
    assign cmd_wr = wr_en && (paddr == CMD_OFS) && (state_r == S_IDLE);

    // Verdict is formed before any flash action is started
    fsg_cmd_check u_check (
        .op        (op_r),
        .blk_first (first_r),
        .blk_last  (last_r),
        .flags     (flags_r),
        .boot_end  (boot_end_r),
        .allow     (allow)
    );

    // Events last one cycle each and feed only the sticky status bits
    assign ev_rej  = (state_r == S_CHECK) && !allow;
    assign ev_done = ((state_r == S_RUN) && flash_done)
                  || ((state_r == S_CHECK) && allow && (op_r == OP_SEC));

    // APB handshake: one wait cycle so read data can come from a register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !mapped;
        end
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            CMD_OFS: begin
                rd_mux = {8'h00, last_r, first_r, 5'h00, op_r};
            end
            SEC_REQ_OFS: begin
                rd_mux = {16'h0000, req_end_r, 3'h0, req_flags_r};
            end
            FLAGS_OFS: begin
                rd_mux = {16'h0000, boot_end_r, 3'h0, flags_r};
            end
            STATUS_OFS: begin
                // Busy is live state; result bits hold until the next check
                rd_mux = {25'h0000000, op_r, 1'b0, rej_r, acc_r, state_r != S_IDLE};
            end
            INT_STAT_OFS: begin
                rd_mux = {30'h00000000, int_stat_r};
            end
            INT_MASK_OFS: begin
                rd_mux = {30'h00000000, int_mask_r};
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured as ready rises
    // Capturing one cycle early keeps the output straight from a flip-flop,
    // at the cost of the single wait state that every access pays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && penable && !pready_r && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    // Command capture, held until the sequencer is idle again
    // Bits outside the opcode and the block range are ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_r    <= OP_NONE;
            first_r <= 8'h00;
            last_r  <= 8'h00;
        end else if (cmd_wr) begin
            op_r    <= pwdata[CMD_OP_LSB +: 3];
            first_r <= pwdata[CMD_BLK0_LSB +: 8];
            last_r  <= pwdata[CMD_BLK1_LSB +: 8];
        end
    end

    // Staged security request; writing it changes no enforcement
    // The two-supply build strips the boot bit and end block on the way in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_flags_r <= FLAGS_RST;
            req_end_r   <= BOOT_END_RST;
        end else if (wr_en && (paddr == SEC_REQ_OFS)) begin
            req_flags_r <= pwdata[FLG_LSB +: NFLAGS] & flag_mask;
            req_end_r   <= SINGLE_SUPPLY ? pwdata[BOOT_END_LSB +: 8] : BOOT_END_RST;
        end
    end

    // Sequencer: check, then run the flash or report a refusal
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (cmd_wr) begin
                        state_r <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    // Security command needs no flash engine cycle here
                    if (allow && (op_r != OP_SEC)) begin
                        state_r <= S_RUN;
                    end else begin
                        state_r <= S_IDLE;
                    end
                end
                S_RUN: begin
                    // No timeout: a silent flash engine keeps the gate busy
                    if (flash_done) begin
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Flash engine request, only ever for an accepted command
    // Operation and range stay on the outputs after the pulse so the engine
    // may sample them late; they change only when the next command starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_r  <= 1'b0;
            fop_r    <= OP_NONE;
            ffirst_r <= 8'h00;
            flast_r  <= 8'h00;
        end else begin
            start_r <= (state_r == S_CHECK) && allow && (op_r != OP_SEC);
            if ((state_r == S_CHECK) && allow && (op_r != OP_SEC)) begin
                fop_r    <= op_r;
                ffirst_r <= first_r;
                flast_r  <= last_r;
            end
        end
    end

    // Enforced flags: set by security command, partly cleared by chip erase
    // Flags are volatile here: reset returns the device to an open state
    // Chip-erase and boot-protect disables survive a completed chip erase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r    <= FLAGS_RST;
            boot_end_r <= BOOT_END_RST;
        end else if ((state_r == S_CHECK) && allow && (op_r == OP_SEC)) begin
            // Flags only accumulate, so boot protect is never dropped
            flags_r <= flags_r | (req_flags_r & flag_mask);
            // Boot area is frozen once protection is in force
            if (!flags_r[F_BOOT_PROT]) begin
                boot_end_r <= req_end_r;
            end
        end else if ((state_r == S_RUN) && flash_done && (fop_r == OP_CHIP)) begin
            flags_r[F_BLK_DIS]  <= 1'b0;
            flags_r[F_PROG_DIS] <= 1'b0;
            flags_r[F_READ_DIS] <= 1'b0;
        end
    end

    // Result of the last command
    // Both bits are rewritten together when the next command is checked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 1'b0;
            rej_r <= 1'b0;
        end else if (state_r == S_CHECK) begin
            acc_r <= allow;
            rej_r <= !allow;
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_r <= 2'h0;
        end else begin
            for (int i = 0; i < NIRQ; i++) begin
                if ((i == IRQ_DONE && ev_done) || (i == IRQ_REJ && ev_rej)) begin
                    int_stat_r[i] <= 1'b1;
                end else if (wr_en && (paddr == INT_STAT_OFS) && pwdata[i]) begin
                    int_stat_r[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask
    // A masked event still sets its status bit and can be polled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_mask_r <= MASK_RST;
        end else if (wr_en && (paddr == INT_MASK_OFS)) begin
            int_mask_r <= pwdata[NIRQ-1:0];
        end
    end

    // Interrupt level, one cycle behind status
    // The extra register keeps the pin free of glitches across status writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    // Every output is a plain copy of a register
    assign pready      = pready_r;
    assign prdata      = prdata_r;
    assign pslverr     = pslverr_r;
    assign flash_start = start_r;
    assign flash_op    = fop_r;
    assign flash_first = ffirst_r;
    assign flash_last  = flast_r;
    assign irq         = irq_r;
endmodule

// >>> hw/fsg_cmd_check.sv
// Combinational permission check for one flash command against the live flags.
// Assumes flags and boot end are already the enforced copies, not the request.
`timescale 1ns/10ps
module fsg_cmd_check
    import fsg_pkg::*;
(
    input  wire logic [2:0]        op,        // Command opcode
    input  wire logic [7:0]        blk_first, // First block of the range
    input  wire logic [7:0]        blk_last,  // Last block of the range
    input  wire logic [NFLAGS-1:0] flags,     // Enforced protection flags
    input  wire logic [7:0]        boot_end,  // Enforced end boot block
    output logic                   allow      // High when the command may run
);
    logic in_boot; // Range touches the boot area
    logic bad_rng; // Range is reversed

    // Boot area is block zero through the end boot block inclusive
    assign in_boot = flags[F_BOOT_PROT] && (blk_first <= boot_end);
    assign bad_rng = blk_first > blk_last;

    // Permission table, one branch per command
    always_comb begin
        case (op)
            OP_CHIP: begin
                // Program disable alone never blocks a whole-chip erase
                allow = !flags[F_CHIP_DIS] && !flags[F_BOOT_PROT];
            end
            OP_BLOCK: begin
                allow = !flags[F_BLK_DIS] && !flags[F_PROG_DIS]
                     && !flags[F_CHIP_DIS] && !in_boot && !bad_rng;
            end
            OP_PROG: begin
                // Read disable leaves erase and program usable
                allow = !flags[F_PROG_DIS] && !in_boot && !bad_rng;
            end
            OP_READ: begin
                allow = !flags[F_READ_DIS];
            end
            OP_SEC: begin
                allow = 1'b1;
            end
            default: begin
                allow = 1'b0; // Unknown opcodes are refused
            end
        endcase
    end
endmodule

// >>> hw/fsg_pkg.sv
// Package for the flash security command gate: register map, fields, commands.
// Assumes a 32-bit APB slave at 10 MHz; block numbers are eight bits wide.
package fsg_pkg;
    // Register byte offsets
    localparam logic [7:0] CMD_OFS      = 8'h00;
    localparam logic [7:0] SEC_REQ_OFS  = 8'h04;
    localparam logic [7:0] FLAGS_OFS    = 8'h08;
    localparam logic [7:0] STATUS_OFS   = 8'h0C;
    localparam logic [7:0] INT_STAT_OFS = 8'h10;
    localparam logic [7:0] INT_MASK_OFS = 8'h14;

    // Field layout of CMD: opcode, first and last block
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BLK0_LSB = 8;
    localparam int CMD_BLK1_LSB = 16;
    // Field layout of SEC_REQ and FLAGS: flag bits, end boot block
    localparam int FLG_LSB      = 0;
    localparam int BOOT_END_LSB = 8;
    // Flag bit positions
    localparam int F_CHIP_DIS  = 0;
    localparam int F_BLK_DIS   = 1;
    localparam int F_PROG_DIS  = 2;
    localparam int F_READ_DIS  = 3;
    localparam int F_BOOT_PROT = 4;
    localparam int NFLAGS      = 5;
    // STATUS bits
    localparam int ST_BUSY   = 0;
    localparam int ST_ACC    = 1;
    localparam int ST_REJ    = 2;
    localparam int ST_OP_LSB = 4;
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REJ  = 1;
    localparam int NIRQ     = 2;

    // Reset values
    localparam logic [NFLAGS-1:0] FLAGS_RST    = 5'h00;
    localparam logic [7:0]        BOOT_END_RST = 8'h00;
    localparam logic [NIRQ-1:0]   MASK_RST     = 2'h0;

    // Commands of the programming link
    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_CHIP  = 3'h1,
        OP_BLOCK = 3'h2,
        OP_PROG  = 3'h3,
        OP_READ  = 3'h4,
        OP_SEC   = 3'h5
    } op_e;
endpackage

// >>> tb/fsg_flash_model.sv
// Flash engine model: answers each start with a one-cycle done after a delay.
// Assumes the same clock as the gate; ignores the operation itself.
`timescale 1ns/10ps
module fsg_flash_model #(
    parameter int DLY = 3 // Cycles from start to done
)(
    input  wire logic clk,         // System clock
    input  wire logic rst_n,       // Async reset, active low
    input  wire logic flash_start, // Start pulse from the gate
    output logic      flash_done   // Done pulse back
);
    int cnt_r; // Cycles left in the running operation

    // Countdown; a late start would restart it, the gate must not do that
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r      <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt_r == 1);
            if (flash_start) begin
                cnt_r <= DLY;
            end else if (cnt_r != 0) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule

// >>> tb/fsg_gate_monitor.sv
// Checker for the flash security command gate: APB timing and flash start pulses.
// Assumes it is bound to the gate top and sees only its ports.
`timescale 1ns/10ps
module fsg_gate_monitor
    import fsg_pkg::*;
(
    input wire logic       clk,         // System clock
    input wire logic       rst_n,       // Async reset, active low
    input wire logic       psel,        // APB select
    input wire logic       penable,     // APB access phase
    input wire logic       pwrite,      // APB write
    input wire logic [7:0] paddr,       // APB address
    input wire logic       pready,      // APB ready
    input wire logic       pslverr,     // APB error
    input wire logic       flash_start, // Start pulse
    input wire logic [2:0] flash_op,    // Running opcode
    input wire logic [7:0] flash_first, // First block
    input wire logic [7:0] flash_last   // Last block
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Exactly one wait state on every access
    property p_rdy_wait; $rose(psel && penable) |=> pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    property p_rdy_one; pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
    // Mapped words never raise an error
    property p_map_ok;
        pready && paddr <= INT_MASK_OFS && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_map_ok: assert property (p_map_ok) else $error("error on mapped");
    property p_start_one; flash_start |=> !flash_start; endproperty
    a_start_one: assert property (p_start_one) else $error("start too long");
    // Security commands never reach the flash engine
    property p_start_op;
        flash_start |-> flash_op inside {OP_CHIP, OP_BLOCK, OP_PROG, OP_READ};
    endproperty
    a_start_op: assert property (p_start_op) else $error("bad start op");
    // A start follows a command write by two cycles: one check cycle between
    property p_start_cause;
        flash_start |-> $past(pready && pwrite && paddr == CMD_OFS, 2);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start uncaused");
    property p_range;
        flash_start && flash_op inside {OP_BLOCK, OP_PROG} |-> flash_first <= flash_last;
    endproperty
    a_range: assert property (p_range) else $error("reversed range ran");
endmodule

bind flash_security_command_gate fsg_gate_monitor u_mon (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .flash_start(flash_start),
    .flash_op(flash_op), .flash_first(flash_first), .flash_last(flash_last)
);

// >>> tb/tb_flash_security_command_gate.sv
// Testbench for the flash security command gate: APB master and flag scenarios.
// Assumes the flash engine model on the far side and the bound checker.
`timescale 1ns/10ps
module tb_flash_security_command_gate
    import fsg_pkg::*;
;
    logic        clk = 1'b0;      // 10 MHz clock
    logic        rst_n = 1'b0;    // Reset, active low
    logic        psel = 1'b0;     // APB select
    logic        penable = 1'b0;  // APB enable
    logic        pwrite = 1'b0;   // APB direction
    logic [7:0]  paddr = 8'h00;   // APB address
    logic [31:0] pwdata = 32'h0;  // APB write data
    logic        pready;          // APB ready
    logic [31:0] prdata;          // APB read data
    logic        pslverr;         // APB error
    logic        flash_done;      // Done from model
    logic        flash_start;     // Start to model
    logic [2:0]  flash_op;        // Running opcode
    logic [7:0]  flash_first;     // First block
    logic [7:0]  flash_last;      // Last block
    logic        irq;             // Interrupt
    logic [31:0] prdata2;         // Read data of the two-supply build
    logic [31:0] rdat;            // Last read data
    logic        rerr;            // Last error flag
    int          failures = 0;    // Mismatch count
    int          checked = 0;     // Comparison count
    int          starts = 0;      // Start pulses seen

    always #50 clk = ~clk;

    // Count starts so a rejected command can be shown to leave flash alone
    always @(posedge clk) begin
        if (flash_start === 1'b1) begin
            starts <= starts + 1;
        end
    end

    flash_security_command_gate DUT (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .flash_done(flash_done), .flash_start(flash_start),
        .flash_op(flash_op), .flash_first(flash_first), .flash_last(flash_last),
        .irq(irq)
    );
    fsg_flash_model u_flash (
        .clk(clk), .rst_n(rst_n), .flash_start(flash_start), .flash_done(flash_done)
    );
    // Two-supply build on the same bus; only its read data is judged
    flash_security_command_gate #(.SINGLE_SUPPLY(1'b0)) DUT2 (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdata2),
        .pslverr(), .flash_done(flash_done), .flash_start(), .flash_op(),
        .flash_first(), .flash_last(), .irq()
    );

    task automatic final_report;
        $display("summary: %0d checked, %0d failures", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer; holds everything until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll status until the sequencer is idle, bounded
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, 32'h0);
            n++;
        end while (rdat[ST_BUSY] !== 1'b0 && n < 40);
        chk("busy", 32'h0, {31'h0, rdat[ST_BUSY]});
    endtask

    // Issue one flash command and judge acceptance and flash activity
    task automatic run(input logic [2:0] op, input logic [7:0] f, input logic [7:0] l,
                       input logic ok);
        int s;
        s = starts;
        apb(1'b1, CMD_OFS, {8'h00, l, f, 5'h00, op});
        wait_idle();
        chk("accept", {31'h0, ok}, {31'h0, rdat[ST_ACC]});
        chk("reject", {31'h0, !ok}, {31'h0, rdat[ST_REJ]});
        chk("starts", 32'(s) + ok, 32'(starts));
        if (ok) begin
            chk("flash_op", {29'h0, op}, {29'h0, flash_op});
            chk("flash_first", {24'h0, f}, {24'h0, flash_first});
            chk("flash_last", {24'h0, l}, {24'h0, flash_last});
        end
    endtask

    // Stage flags, run the security command, compare the enforced flags
    task automatic sec(input logic [31:0] req, input logic [31:0] ef);
        apb(1'b1, SEC_REQ_OFS, req);
        apb(1'b1, CMD_OFS, {29'h0, OP_SEC});
        wait_idle();
        apb(1'b0, FLAGS_OFS, 32'h0);
        chk("flags", ef, rdat);
    endtask

    task automatic t_regs;
        apb(1'b0, FLAGS_OFS, 32'h0);
        chk("flags_rst", 32'h0, rdat);
        apb(1'b0, INT_MASK_OFS, 32'h0);
        chk("mask_rst", 32'h0, rdat);
        apb(1'b1, FLAGS_OFS, 32'h1F);
        apb(1'b0, FLAGS_OFS, 32'h0);
        chk("flags_ro", 32'h0, rdat);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        $display("test regs done");
    endtask

    task automatic t_read;
        sec(32'h08, 32'h08);
        run(OP_READ, 8'h00, 8'h00, 1'b0);
        run(OP_PROG, 8'h01, 8'h01, 1'b1);
        run(OP_BLOCK, 8'h01, 8'h02, 1'b1);
        apb(1'b1, INT_STAT_OFS, 32'h3);
        apb(1'b1, INT_MASK_OFS, 32'h2);
        run(OP_READ, 8'h00, 8'h00, 1'b0);
        chk("irq_set", 32'h1, {31'h0, irq});
        apb(1'b1, INT_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_mask", 32'h0, {31'h0, irq});
        apb(1'b1, INT_MASK_OFS, 32'h2);
        apb(1'b1, INT_STAT_OFS, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        run(OP_CHIP, 8'h00, 8'h00, 1'b1);
        apb(1'b0, FLAGS_OFS, 32'h0);
        chk("flags", 32'h0, rdat);
        $display("test read done");
    endtask

    task automatic t_prog_blk;
        sec(32'h04, 32'h04);
        run(OP_PROG, 8'h02, 8'h02, 1'b0);
        run(OP_BLOCK, 8'h02, 8'h03, 1'b0);
        run(OP_CHIP, 8'h00, 8'h00, 1'b1);
        sec(32'h02, 32'h02);
        run(OP_BLOCK, 8'h00, 8'h00, 1'b0);
        run(OP_PROG, 8'h00, 8'h01, 1'b1);
        run(OP_PROG, 8'h05, 8'h04, 1'b0);
        run(OP_CHIP, 8'h00, 8'h00, 1'b1);
        apb(1'b0, FLAGS_OFS, 32'h0);
        chk("flags", 32'h0, rdat);
        $display("test prog_blk done");
    endtask

    task automatic t_boot;
        apb(1'b1, SEC_REQ_OFS, 32'h0310);
        run(OP_BLOCK, 8'h02, 8'h02, 1'b1);
        sec(32'h0310, 32'h0310);
        chk("flags_two", 32'h0, prdata2);
        run(OP_BLOCK, 8'h03, 8'h03, 1'b0);
        run(OP_BLOCK, 8'h04, 8'h05, 1'b1);
        run(OP_PROG, 8'h01, 8'h01, 1'b0);
        run(OP_PROG, 8'h04, 8'h04, 1'b1);
        run(OP_CHIP, 8'h00, 8'h00, 1'b0);
        run(OP_READ, 8'h00, 8'h00, 1'b1);
        sec(32'h0000, 32'h0310);
        run(OP_BLOCK, 8'h00, 8'h00, 1'b0);
        sec(32'h0001, 32'h0311);
        run(OP_CHIP, 8'h00, 8'h00, 1'b0);
        run(OP_BLOCK, 8'h04, 8'h04, 1'b0);
        run(OP_PROG, 8'h04, 8'h04, 1'b1);
        run(OP_READ, 8'h00, 8'h00, 1'b1);
        $display("test boot done");
    endtask

    // Main sequence: reset for six cycles, then each scenario in turn
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_read();
        t_prog_blk();
        t_boot();
        final_report();
    end

    // Watchdog: the run needs a few thousand cycles at most
    initial begin
        #2000000;
        failures++;
        $display("ERROR watchdog expected done seen timeout");
        final_report();
    end
endmodule
